/* inc/sadc_pkg.sv */
// Constants and carriers for the converter control block.
// Assumes a 100 MHz mclk; all pins are synchronised inside the top.
`default_nettype none
package sadc_pkg;
	localparam int CLK_NS = 10;
	localparam int POR_NS = 500;
	localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
	localparam int DATA_BITS = 14;
	localparam int SUB_BITS = 2;
	localparam int RES_BITS = DATA_BITS + SUB_BITS;
	localparam int CAL_CAPS = 10;
	localparam int CAL_CYC = 14000;
	localparam int ACQ_MIN = 3;
	localparam int ACQ_CYC = 4;
	localparam int CODE_W = 8;
	localparam int CODE_LSB = 3;
	localparam logic [1:0] RSS_LOW = 2'h0;
	localparam logic [1:0] RSS_HIGH = 2'h1;
	localparam logic [1:0] RSS_FLOAT = 2'h2;
	typedef enum logic [2:0] {
		ST_POR = 3'h0,
		ST_HALT = 3'h1,
		ST_CAL = 3'h2,
		ST_IDLE = 3'h3,
		ST_SAMPLE_START_N = 3'h4,
		ST_SHDN = 3'h5
	} sadc_state_e;
	typedef struct packed {
		logic sample_start_n_clk;
		logic start_n;
		logic reset_n;
		logic cs_n;
		logic shift_clk;
		logic comp;
		logic [1:0] rss;
	} sadc_pins_s;
endpackage
`default_nettype wire

/* verilog/sadc_ctrl.sv */
// Converter sequencing: calibration, acquisition, bit search, serial out.
// Assumes analog switches and comparator outside; pins arrive unsynchronised.
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo
	import sadc_pkg::*;
#(
	parameter int W = RES_BITS,
	parameter int DEPTH = 4
)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} sadc_fifo_s;
	sadc_fifo_s q_r, q_nxt;
	logic push, pop;
	assign in_ready = q_r.cnt != FULL;
	assign out_valid = q_r.cnt != '0;
	assign out_data = q_r.mem[q_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Pointers wrap naturally; DEPTH must be a power of two
	always_comb
	begin
		q_nxt = q_r;
		if (push)
		begin
			q_nxt.mem[q_r.wp] = in_data;
			q_nxt.wp = q_r.wp + 1'b1;
		end
		if (pop)
		begin
			q_nxt.rp = q_r.rp + 1'b1;
		end
		q_nxt.cnt = q_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			q_r <= '0;
		end
		else
		begin
			q_r <= q_nxt;
		end
	end
endmodule

module sadc_ctrl
	import sadc_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_CYC,
	parameter int FIFO_DEPTH = 4
)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic sample_start_n_clk,
	input wire logic sample_start_n,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic shift_clk,
	input wire logic comp_out,
	input wire logic [1:0] range_shutdown_select,
	output logic end_of_sample_start_n,
	output logic serial_result_out,
	output logic serial_result_oe,
	output logic track_all,
	output logic msb_tie_ref,
	output logic shutdown,
	output logic [RES_BITS-1:0] trial_bits,
	output logic cal_busy,
	output logic [3:0] cal_cap_sel,
	output logic [CAL_CAPS-1:0][CODE_W-1:0] corr_code
);
	localparam int TRIALS = CAL_CYCLES / CAL_CAPS;
	typedef struct packed {
		sadc_pins_s s1;
		sadc_pins_s s2;
		logic cclk_d;
		logic sclk_d;
		sadc_state_e st;
		logic [5:0] por_cnt;
		logic [2:0] acq_cnt;
		logic pend;
		logic [4:0] step;
		logic [RES_BITS-1:0] trial;
		logic sample_start_n_bit;
		logic [3:0] cap;
		logic [15:0] tcnt;
		logic [15:0] acc;
		logic [CAL_CAPS-1:0][CODE_W-1:0] codes;
		logic eoc;
		logic [RES_BITS-1:0] sh;
		logic sdo;
	} sadc_ctrl_s;
	sadc_ctrl_s r, n;
	sadc_pins_s pin_in;
	logic fe, sfe, shdn, push, pop, f_ready, f_valid;
	logic [RES_BITS-1:0] f_data;
	logic [15:0] acc_new;
	logic [3:0] idx;

	assign pin_in = '{sample_start_n_clk, sample_start_n, reset_n, chip_select_n,
		shift_clk, comp_out, range_shutdown_select};
	assign fe = r.cclk_d && !r.s2.sample_start_n_clk;
	assign sfe = r.sclk_d && !r.s2.shift_clk;
	assign shdn = r.s2.rss == RSS_LOW;
	// Shift register is free during a conversion, so results drain then too
	assign pop = r.s2.cs_n || r.st == ST_SAMPLE_START_N;

	sadc_fifo #(.W(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(push),
		.in_ready(f_ready),
		.in_data(r.trial),
		.out_valid(f_valid),
		.out_ready(pop),
		.out_data(f_data)
	);

	always_comb
	begin
		n = r;
		push = 1'b0;
		idx = 4'(RES_BITS - 1) - r.step[3:0];
		acc_new = r.acc + 16'(r.s2.comp);
		n.s1 = pin_in;
		n.s2 = r.s1;
		n.cclk_d = r.s2.sample_start_n_clk;
		n.sclk_d = r.s2.shift_clk;
		case (r.st)
			ST_POR:
			begin
				n.por_cnt = r.s2.reset_n ? r.por_cnt + 6'h01 : 6'h00;
				if (r.por_cnt == 6'(POR_CYC - 1))
				begin
					n.st = ST_CAL;
					n.eoc = 1'b1;
				end
			end
			ST_HALT:
			begin
				if (r.s2.reset_n)
				begin
					n.st = ST_CAL;
					n.eoc = 1'b1;
					n.cap = 4'h0;
					n.tcnt = 16'h0000;
					n.acc = 16'h0000;
					n.acq_cnt = 3'h0;
					n.trial = '0;
				end
			end
			ST_CAL:
			begin
				if (fe)
				begin
					n.acc = acc_new;
					n.tcnt = r.tcnt + 16'h0001;
					if (r.tcnt == 16'(TRIALS - 1))
					begin
						n.codes[r.cap] = acc_new[CODE_LSB +: CODE_W];
						n.acc = 16'h0000;
						n.tcnt = 16'h0000;
						n.cap = r.cap + 4'h1;
						if (r.cap == 4'(CAL_CAPS - 1))
						begin
							n.st = ST_IDLE;
							n.eoc = 1'b0;
							n.cap = 4'h0;
						end
					end
				end
			end
			ST_IDLE:
			begin
				if (!r.s2.start_n)
				begin
					n.pend = 1'b1;
				end
				if (shdn)
				begin
					n.st = ST_SHDN;
					n.pend = 1'b0;
				end
				else if (fe)
				begin
					if (r.acq_cnt != 3'(ACQ_CYC))
					begin
						n.acq_cnt = r.acq_cnt + 3'h1;
					end
					if ((r.pend || !r.s2.start_n) && f_ready &&
						r.acq_cnt >= 3'(ACQ_MIN))
					begin
						n.st = ST_SAMPLE_START_N;
						n.pend = 1'b0;
						n.step = 5'h00;
						n.trial = {1'b1, {(RES_BITS-1){1'b0}}};
					end
				end
			end
			ST_SAMPLE_START_N:
			begin
				n.pend = 1'b0;
				if (fe)
				begin
					if (r.step == 5'(RES_BITS))
					begin
						n.eoc = 1'b0;
						push = 1'b1;
						n.st = ST_IDLE;
						n.acq_cnt = 3'h0;
					end
					else
					begin
						if (r.step == 5'h00)
						begin
							n.eoc = 1'b1;
						end
						n.trial[idx] = !r.s2.comp;
						n.sample_start_n_bit = !r.s2.comp;
						if (idx != 4'h0)
						begin
							n.trial[idx - 4'h1] = 1'b1;
						end
						n.step = r.step + 5'h01;
					end
				end
			end
			ST_SHDN:
			begin
				if (!shdn)
				begin
					n.st = ST_IDLE;
					n.acq_cnt = 3'h0;
				end
			end
			default:
			begin
				n.st = ST_HALT;
			end
		endcase
		if (!r.s2.reset_n && r.st != ST_POR)
		begin
			n.st = ST_HALT;
			n.eoc = 1'b0;
			n.pend = 1'b0;
		end
		if (f_valid && pop)
		begin
			n.sh = f_data;
		end
		else if (sfe && r.st != ST_SAMPLE_START_N)
		begin
			n.sh = {r.sh[RES_BITS-2:0], 1'b0};
		end
		n.sdo = r.st == ST_SAMPLE_START_N ? r.sample_start_n_bit : r.sh[RES_BITS-1];
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			r <= '0;
		end
		else
		begin
			r <= n;
		end
	end

	assign end_of_sample_start_n = r.eoc;
	assign serial_result_out = r.sdo;
	assign serial_result_oe = !r.s2.cs_n;
	assign track_all = r.st == ST_IDLE;
	assign msb_tie_ref = track_all && r.s2.rss == RSS_FLOAT;
	assign shutdown = r.st == ST_SHDN;
	assign trial_bits = r.trial;
	assign cal_busy = r.st == ST_CAL;
	assign cal_cap_sel = r.cap;

	genvar gi;
	generate
		for (gi = 0; gi < CAL_CAPS; gi++)
		begin : g_corr
			assign corr_code[gi] = r.trial[RES_BITS-1-gi] ?
				r.codes[gi] : '0;
		end
	endgenerate

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_idle_flag_low: assert property ((r.st == ST_SHDN || r.st == ST_HALT) |-> !r.eoc)
		else $error("flag high in shutdown or halt");
	a_dout_hiz_sel: assert property (##2 1 |-> serial_result_oe == !$past(chip_select_n, 2))
		else $error("output enable does not follow chip select");
	a_sample_start_n_begin_acq: assert property ((r.st == ST_IDLE && n.st == ST_SAMPLE_START_N)
		|-> fe && r.acq_cnt >= 3'(ACQ_MIN))
		else $error("conversion began before acquisition");
	a_eoc_rise_edge: assert property ((r.st == ST_SAMPLE_START_N && fe && r.step == 5'h00)
		|=> r.eoc && r.trial[RES_BITS-1] == !$past(r.s2.comp))
		else $error("flag or MSB wrong on first edge");
	a_bit_decide: assert property ((r.st == ST_SAMPLE_START_N && fe && r.step < 5'(RES_BITS))
		|=> r.sample_start_n_bit == !$past(r.s2.comp))
		else $error("bit decision inverted");
	a_eoc_fall_end: assert property ((r.st == ST_SAMPLE_START_N && fe && r.step == 5'(RES_BITS))
		|=> !r.eoc && r.st == ST_IDLE && r.acq_cnt == 3'h0)
		else $error("conversion end wrong");
	a_start_ignored: assert property ((r.st == ST_SAMPLE_START_N && !fe) |=> r.st == ST_SAMPLE_START_N || r.st == ST_HALT)
		else $error("conversion left without an edge");
	a_codes_kept: assert property ((r.st != ST_CAL) |=> $stable(r.codes))
		else $error("codes changed outside calibration");
	a_reset_recal: assert property ((r.st == ST_HALT && r.s2.reset_n) |=> r.st == ST_CAL && r.eoc)
		else $error("reset release did not calibrate");
	a_shdn_decode: assert property ((r.st == ST_IDLE && shdn && r.s2.reset_n) |=> r.st == ST_SHDN)
		else $error("shutdown not entered");
	a_shift_next: assert property ((r.st != ST_SAMPLE_START_N && !r.s2.cs_n && sfe)
		|=> r.sh == {$past(r.sh[RES_BITS-2:0]), 1'b0})
		else $error("serial shift wrong");

	c_sample_start_n_done: cover property (r.st == ST_SAMPLE_START_N ##1 r.st == ST_IDLE);
	c_cal_done: cover property (r.st == ST_CAL ##1 r.st == ST_IDLE);
	c_fifo_full: cover property (!f_ready);
	c_shdn: cover property (r.st == ST_SHDN);
endmodule
`default_nettype wire

/* dv/sadc_host_model.sv */
// Host side: free-running conversion clock and the comparator.
// Assumes the analog level is held as a 16-bit target code.
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model
	import sadc_pkg::*;
(
	input wire logic [RES_BITS-1:0] trial_bits,
	input wire logic [RES_BITS-1:0] target,
	input wire logic cal_busy,
	input wire logic cal_level,
	output logic sample_start_n_clk,
	output logic comp_out
);
	initial
	begin
		sample_start_n_clk = 1'b0;
		forever #40 sample_start_n_clk = ~sample_start_n_clk;
	end
	// High when the trial code overshoots the held level; a fixed level while calibrating
	assign comp_out = cal_busy ? cal_level : (trial_bits > target);
endmodule
`default_nettype wire

/* dv/sadc_ctrl_tb_top.sv */
// Bench for the converter control block with a queue model of results.
// Assumes the host model makes sample_start_n_clk and answers as comparator.
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_tb_top;
	import sadc_pkg::*;
	localparam int CAL_N = 100;
	logic mclk;
	logic rst;
	logic start_n;
	logic reset_n;
	logic cs_n;
	logic sclk;
	logic [1:0] rss;
	logic sample_start_n_clk;
	logic comp;
	logic eoc;
	logic sdo;
	logic oe;
	logic trk;
	logic tie;
	logic shdn;
	logic cal;
	logic [RES_BITS-1:0] trial;
	logic [RES_BITS-1:0] target;
	logic cal_lvl;
	logic [3:0] cap_sel;
	logic [CAL_CAPS-1:0][CODE_W-1:0] corr;
	logic [15:0] q[$];
	int n_errors;
	int cmp_count;
	int cycles;
	int fe_cnt;
	int f0;
	sadc_host_model host (.trial_bits(trial), .target(target), .cal_busy(cal), .cal_level(cal_lvl),
		.sample_start_n_clk(sample_start_n_clk), .comp_out(comp));
	sadc_ctrl #(.CAL_CYCLES(CAL_N)) dut (.mclk(mclk), .rst(rst), .sample_start_n_clk(sample_start_n_clk),
		.sample_start_n(start_n), .reset_n(reset_n), .chip_select_n(cs_n), .shift_clk(sclk),
		.comp_out(comp), .range_shutdown_select(rss), .end_of_sample_start_n(eoc), .serial_result_out(sdo),
		.serial_result_oe(oe), .track_all(trk), .msb_tie_ref(tie), .shutdown(shdn),
		.trial_bits(trial), .cal_busy(cal), .cal_cap_sel(cap_sel), .corr_code(corr));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(negedge sample_start_n_clk)
		fe_cnt++;
	task automatic final_report();
		if (n_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_errors++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_eoc(input logic lvl);
		int k;
		k = 0;
		while (eoc !== lvl && k < 3000)
		begin
			@(negedge mclk);
			k++;
		end
		chk({15'h0, eoc}, {15'h0, lvl});
	endtask
	task automatic chk_corr(input logic [15:0] w, input int lvl);
		logic [CODE_W-1:0] code;
		code = CODE_W'(((CAL_N / CAL_CAPS) * lvl) >> CODE_LSB);
		for (int i = 0; i < CAL_CAPS; i++)
			chk(16'(corr[i]), w[15 - i] ? 16'(code) : 16'h0000);
	endtask
	// Waits out acquisition first so the request falls in the two-edge case
	task automatic convert(input logic [15:0] t);
		target = t;
		repeat (4) @(negedge sample_start_n_clk);
		repeat (4) @(negedge mclk);
		f0 = fe_cnt;
		start_n = 1'b0;
		wait_eoc(1'b1);
		chk(16'(fe_cnt - f0), 16'h2);
		f0 = fe_cnt;
		start_n = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge sample_start_n_clk);
			chk({15'h0, sdo}, {15'h0, t[15 - i]});
		end
		wait_eoc(1'b0);
		chk(16'(fe_cnt - f0), 16'h10);
		chk(trial, t);
		q.push_back(t);
	endtask
	task automatic read_word(input logic [15:0] w);
		cs_n = 1'b0;
		repeat (4) @(negedge mclk);
		chk({15'h0, oe}, 16'h1);
		for (int i = 0; i < 17; i++)
		begin
			chk({15'h0, sdo}, {15'h0, (i < 16) ? w[15 - i] : 1'b0});
			sclk = 1'b0;
			repeat (10) @(negedge mclk);
			sclk = 1'b1;
			repeat (10) @(negedge mclk);
		end
		cs_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk({15'h0, oe}, 16'h0);
	endtask
	initial
	begin
		void'($urandom(5082));
		rst = 1'b1;
		start_n = 1'b1;
		reset_n = 1'b1;
		cs_n = 1'b1;
		sclk = 1'b1;
		rss = RSS_HIGH;
		target = 16'h0;
		cal_lvl = 1'b1;
		n_errors = 0;
		cmp_count = 0;
		cycles = 0;
		fe_cnt = 0;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		wait_eoc(1'b1);
		chk({15'h0, cal}, 16'h1);
		repeat (25) @(negedge sample_start_n_clk);
		chk(16'(cap_sel), 16'(25 / (CAL_N / CAL_CAPS)));
		wait_eoc(1'b0);
		chk(16'(cap_sel), 16'h0);
		convert(16'h0000);
		chk_corr(16'h0000, 1);
		convert(16'hFFFF);
		chk_corr(16'hFFFF, 1);
		convert(16'($urandom));
		chk_corr(q[$], 1);
		read_word(q[$]);
		target = 16'($urandom);
		start_n = 1'b0;
		wait_eoc(1'b1);
		wait_eoc(1'b0);
		f0 = fe_cnt;
		wait_eoc(1'b1);
		chk(16'(fe_cnt - f0), 16'(ACQ_CYC + 1));
		start_n = 1'b1;
		wait_eoc(1'b0);
		chk(trial, target);
		read_word(target);
		rss = RSS_LOW;
		repeat (10) @(negedge mclk);
		chk({15'h0, shdn}, 16'h1);
		start_n = 1'b0;
		repeat (200) @(negedge mclk);
		chk({15'h0, eoc}, 16'h0);
		start_n = 1'b1;
		rss = RSS_HIGH;
		repeat (10) @(negedge mclk);
		chk({14'h0, trk, tie}, 16'h2);
		rss = RSS_FLOAT;
		repeat (10) @(negedge mclk);
		chk({14'h0, trk, tie}, 16'h3);
		convert(16'hFFFF);
		chk_corr(16'hFFFF, 1);
		cal_lvl = 1'b0;
		reset_n = 1'b0;
		repeat (20) @(negedge mclk);
		chk({15'h0, eoc}, 16'h0);
		reset_n = 1'b1;
		wait_eoc(1'b1);
		wait_eoc(1'b0);
		convert(16'($urandom) | 16'hFFC0);
		chk_corr(q[$], 0);
		final_report();
	end
endmodule
`default_nettype wire
